//--- iilc_defs.vh
// Purpose: Constants for the issue interlock and latency control block.
// Assumes: 16 architectural registers, 100 MHz core clock.
// Notes:   All latencies are in core clock cycles.
`ifndef IILC_DEFS_VH
`define IILC_DEFS_VH

// ****************************************************************
// Instruction classes
// ****************************************************************
`define IILC_CLS_W       4
`define IILC_CLS_DP      4'h0
`define IILC_CLS_DP_SIMM 4'h1
`define IILC_CLS_DP_SREG 4'h2
`define IILC_CLS_LDR     4'h3
`define IILC_CLS_STR     4'h4
`define IILC_CLS_LDRD    4'h5
`define IILC_CLS_STRD    4'h6
`define IILC_CLS_LDM     4'h7
`define IILC_CLS_STM     4'h8
`define IILC_CLS_MUL     4'h9
`define IILC_CLS_MULS    4'ha
`define IILC_CLS_PLD     4'hb

// ****************************************************************
// Latency figures
// ****************************************************************
`define IILC_CNT_W       5
`define IILC_ISS_ONE     5'h01
`define IILC_ISS_TWO     5'h02
`define IILC_LDRD_R12    5'h02
`define IILC_LDM_BASE    5'h02
`define IILC_LDM_PAIR    5'h04
`define IILC_PAIR_REGS   5'h02
`define IILC_RES_DP      5'h01
`define IILC_RES_SIMM    5'h02
`define IILC_RES_SREG    5'h02
`define IILC_RES_LDR     5'h03
`define IILC_RES_LDRD0   5'h03
`define IILC_RES_LDRD1   5'h04
`define IILC_MUL_BASE    5'h01
`define IILC_RES_MUL_MIN 5'h02
`define IILC_MEM_GAP     5'h01
`define IILC_R12         4'hc
`define IILC_NFILL       4
`define IILC_NWBUF       8
`define IILC_CNT_ZERO    5'h00
`define IILC_CNT_ONE     5'h01

`endif

//--- iilc_scoreboard.v
// Purpose: Per-register countdown of cycles until a result is usable.
// Assumes: Two set ports per cycle, one for each of up to two destination registers.
// Notes:   A count of 1 means the next cycle may consume the value.
`timescale 1ns/1ps
`include "iilc_defs.vh"

module iilc_scoreboard (
  input  wire                    ref_clk_i,
  input  wire                    rst_i,
  input  wire                    set0_i,
  input  wire [3:0]              set0_reg_i,
  input  wire [`IILC_CNT_W-1:0]  set0_cnt_i,
  input  wire                    set1_i,
  input  wire [3:0]              set1_reg_i,
  input  wire [`IILC_CNT_W-1:0]  set1_cnt_i,
  input  wire                    shf_i,
  input  wire [15:0]             shf_mask_i,
  output wire [16*`IILC_CNT_W-1:0] cnt_o,
  output wire [15:0]             shf_o
);

  // ****************************************************************
  // Counter array
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_reg
      reg [`IILC_CNT_W-1:0] cnt_q;
      reg                   shf_q;
      // Load on issue, else count down to zero
      always @(posedge ref_clk_i) begin
        if (rst_i) begin
          cnt_q <= `IILC_CNT_ZERO;
          shf_q <= 1'b0;
        end else if (set1_i && set1_reg_i == g) begin
          cnt_q <= set1_cnt_i;
          shf_q <= 1'b0;
        end else if (set0_i && set0_reg_i == g) begin
          cnt_q <= set0_cnt_i;
          shf_q <= shf_i & shf_mask_i[g];
        end else if (cnt_q != `IILC_CNT_ZERO) begin
          cnt_q <= cnt_q - `IILC_CNT_ONE;
        end
      end
      assign cnt_o[g*`IILC_CNT_W +: `IILC_CNT_W] = cnt_q;
      assign shf_o[g] = shf_q;
    end
  endgenerate

endmodule // iilc_scoreboard

//--- iilc_issue_ctrl.v
// Purpose: Issue stage interlock: holds instructions until operands,
//          the multiplier and memory buffers are ready.
// Assumes: Decode presents one instruction with valid; it waits on stall.
// Notes:   Multiply duration comes from the multiplier as a cycle count.
`timescale 1ns/1ps
`include "iilc_defs.vh"

module iilc_issue_ctrl (
  input  wire                   ref_clk_i,
  input  wire                   rst_i,
  input  wire                   dec_valid_i,
  input  wire [`IILC_CLS_W-1:0] dec_class_i,
  input  wire [3:0]             dec_rd_i,
  input  wire [3:0]             dec_rn_i,
  input  wire                   dec_rn_use_i,
  input  wire [3:0]             dec_rm_i,
  input  wire                   dec_rm_use_i,
  input  wire [3:0]             dec_rs_i,
  input  wire                   dec_rs_use_i,
  input  wire                   dec_shift_imm_i,
  input  wire                   dec_rotate_right_extend_i,
  input  wire [15:0]            dec_reg_list_i,
  input  wire [1:0]             mul_cycles_i,
  input  wire                   dc_miss_i,
  input  wire                   fill_done_i,
  input  wire                   wbuf_drain_i,
  output reg                    issue_o,
  output reg                    stall_o,
  output reg                    mem_issue_o,
  output reg                    dual_word_o,
  output reg  [3:0]             pair_reg_o
);

  // ****************************************************************
  // Class decode
  // ****************************************************************
  function is_mem;
    input [`IILC_CLS_W-1:0] c;
    begin
      is_mem = (c == `IILC_CLS_LDR) || (c == `IILC_CLS_STR) ||
               (c == `IILC_CLS_LDRD) || (c == `IILC_CLS_STRD) ||
               (c == `IILC_CLS_LDM) || (c == `IILC_CLS_STM) ||
               (c == `IILC_CLS_PLD);
    end
  endfunction

  function is_store;
    input [`IILC_CLS_W-1:0] c;
    begin
      is_store = (c == `IILC_CLS_STR) || (c == `IILC_CLS_STRD) ||
                 (c == `IILC_CLS_STM);
    end
  endfunction

  function is_load;
    input [`IILC_CLS_W-1:0] c;
    begin
      is_load = (c == `IILC_CLS_LDR) || (c == `IILC_CLS_LDRD) ||
                (c == `IILC_CLS_LDM) || (c == `IILC_CLS_PLD);
    end
  endfunction

  // Count of set bits in a register list
  function [`IILC_CNT_W-1:0] popcnt;
    input [15:0] v;
    integer k;
    begin
      popcnt = `IILC_CNT_ZERO;
      for (k = 0; k < 16; k = k + 1)
        popcnt = popcnt + {4'h0, v[k]};
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [`IILC_CNT_W-1:0]  busy_q;      // Issue occupancy left
  reg  [`IILC_CNT_W-1:0]  mul_busy_q;  // Multiplier occupancy left
  reg                     after_ldrd_q;
  reg                     after_ldm_q;
  reg  [2:0]              fill_q;
  reg  [3:0]              wbuf_q;
  wire [16*`IILC_CNT_W-1:0] sb_cnt;
  wire [15:0]             sb_shf;

  reg                     go;
  reg                     hazard;
  reg  [`IILC_CNT_W-1:0]  occ;
  reg  [`IILC_CNT_W-1:0]  res0;
  reg  [`IILC_CNT_W-1:0]  res1;
  reg  [`IILC_CNT_W-1:0]  mlat;
  reg  [`IILC_CNT_W-1:0]  mres;        // Multiply result latency
  reg                     set1;
  reg  [3:0]              rd1;
  reg                     cnt_rd;
  wire [`IILC_CNT_W-1:0]  nregs = popcnt(dec_reg_list_i);
  // Plain ALU results reach a shift-immediate consumer one cycle late
  wire                    shf_prod = ~dec_rotate_right_extend_i &
                                     (dec_class_i == `IILC_CLS_DP ||
                                      dec_class_i == `IILC_CLS_DP_SIMM);

  // Operand hazard against the scoreboard; shift-immediate use adds a cycle
  function src_wait;
    input [3:0] r;
    input       use_it;
    input       shift_use;
    reg   [`IILC_CNT_W-1:0] c;
    begin
      c = sb_cnt[r*`IILC_CNT_W +: `IILC_CNT_W];
      src_wait = use_it && ((c > `IILC_CNT_ONE) ||
                 (c == `IILC_CNT_ONE && shift_use && sb_shf[r]));
    end
  endfunction

  // ****************************************************************
  // Issue decision
  // ****************************************************************
  always @* begin
    mlat = {3'h0, mul_cycles_i} + `IILC_MUL_BASE;
    // A consumer always waits at least one cycle behind a multiply
    mres = (mlat < `IILC_RES_MUL_MIN) ? `IILC_RES_MUL_MIN : mlat;
    hazard = src_wait(dec_rn_i, dec_rn_use_i, 1'b0) |
             src_wait(dec_rm_i, dec_rm_use_i, dec_shift_imm_i) |
             src_wait(dec_rs_i, dec_rs_use_i, 1'b0);
    if (busy_q > `IILC_CNT_ONE)
      hazard = 1'b1;
    if (after_ldm_q)
      hazard = 1'b1;
    if (after_ldrd_q && is_mem(dec_class_i))
      hazard = 1'b1;
    if ((dec_class_i == `IILC_CLS_MUL || dec_class_i == `IILC_CLS_MULS) &&
        mul_busy_q > `IILC_CNT_ONE)
      hazard = 1'b1;
    if (is_load(dec_class_i) && fill_q == `IILC_NFILL)
      hazard = 1'b1;
    if (is_store(dec_class_i) && wbuf_q == `IILC_NWBUF)
      hazard = 1'b1;
    go = dec_valid_i & ~hazard;
    // Issue occupancy and result latency per class
    occ = `IILC_ISS_ONE;
    res0 = `IILC_RES_DP;
    res1 = `IILC_CNT_ZERO;
    set1 = 1'b0;
    rd1 = dec_rd_i | 4'h1;
    cnt_rd = 1'b1;
    case (dec_class_i)
      `IILC_CLS_DP_SIMM: res0 = `IILC_RES_DP;
      `IILC_CLS_DP_SREG: begin
        occ = `IILC_ISS_TWO;
        res0 = `IILC_RES_SREG;
      end
      `IILC_CLS_LDR: res0 = `IILC_RES_LDR;
      `IILC_CLS_STR, `IILC_CLS_STRD, `IILC_CLS_STM, `IILC_CLS_PLD: begin
        cnt_rd = 1'b0;
        if (dec_class_i == `IILC_CLS_STRD)
          occ = `IILC_ISS_TWO;
        if (dec_class_i == `IILC_CLS_STM)
          occ = (nregs == `IILC_PAIR_REGS) ? `IILC_LDM_PAIR : `IILC_LDM_BASE + nregs;
      end
      `IILC_CLS_LDRD: begin
        occ = (dec_rd_i == `IILC_R12) ? `IILC_LDRD_R12 : `IILC_ISS_ONE;
        res0 = `IILC_RES_LDRD0;
        res1 = `IILC_RES_LDRD1;
        set1 = 1'b1;
      end
      `IILC_CLS_LDM: begin
        occ = (nregs == `IILC_PAIR_REGS) ? `IILC_LDM_PAIR : `IILC_LDM_BASE + nregs;
        cnt_rd = 1'b0;
      end
      `IILC_CLS_MUL: res0 = mres;
      `IILC_CLS_MULS: begin
        occ = mlat;
        res0 = mres;
      end
      default: res0 = `IILC_RES_DP;
    endcase
    if (dec_rotate_right_extend_i) begin
      occ = `IILC_ISS_TWO;
      res0 = `IILC_RES_SREG;
    end
  end

  // ****************************************************************
  // Scoreboard
  // ****************************************************************
  iilc_scoreboard u_sb (
    .ref_clk_i  (ref_clk_i),
    .rst_i      (rst_i),
    .set0_i     (go & cnt_rd),
    .set0_reg_i (dec_rd_i),
    .set0_cnt_i (res0),
    .set1_i     (go & set1),
    .set1_reg_i (rd1),
    .set1_cnt_i (res1),
    .shf_i      (shf_prod),
    .shf_mask_i (16'hffff),
    .cnt_o      (sb_cnt),
    .shf_o      (sb_shf)
  );

  // ****************************************************************
  // Occupancy, resources and outputs
  // ****************************************************************
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_q <= `IILC_CNT_ZERO;
      mul_busy_q <= `IILC_CNT_ZERO;
      after_ldrd_q <= 1'b0;
      after_ldm_q <= 1'b0;
      fill_q <= 3'h0;
      wbuf_q <= 4'h0;
      issue_o <= 1'b0;
      stall_o <= 1'b0;
      mem_issue_o <= 1'b0;
      dual_word_o <= 1'b0;
      pair_reg_o <= 4'h0;
    end else begin
      if (go)
        busy_q <= occ;
      else if (busy_q != `IILC_CNT_ZERO)
        busy_q <= busy_q - `IILC_CNT_ONE;
      if (go && (dec_class_i == `IILC_CLS_MUL || dec_class_i == `IILC_CLS_MULS))
        mul_busy_q <= mlat;
      else if (mul_busy_q != `IILC_CNT_ZERO)
        mul_busy_q <= mul_busy_q - `IILC_CNT_ONE;
      // One-cycle penalty window after double loads, occupancy-length window after multiple loads
      if (go)
        after_ldrd_q <= (dec_class_i == `IILC_CLS_LDRD);
      else if (!after_ldrd_q || !dec_valid_i || is_mem(dec_class_i))
        after_ldrd_q <= 1'b0;
      if (go)
        after_ldm_q <= (dec_class_i == `IILC_CLS_LDM);
      else if (busy_q <= `IILC_ISS_TWO)
        after_ldm_q <= 1'b0;                                   // Occupancy alone sets the wait
      // Fill buffer count: allocate on miss, release on fill
      fill_q <= fill_q + {2'h0, dc_miss_i} - {2'h0, fill_done_i & (fill_q != 3'h0)};
      wbuf_q <= wbuf_q + {3'h0, go & is_store(dec_class_i)} -
                {3'h0, wbuf_drain_i & (wbuf_q != 4'h0)};
      issue_o <= go;
      stall_o <= dec_valid_i & hazard;
      mem_issue_o <= go & is_mem(dec_class_i);
      dual_word_o <= go & (dec_class_i == `IILC_CLS_LDRD ||
                           dec_class_i == `IILC_CLS_STRD);
      pair_reg_o <= dec_rd_i & 4'he;
    end
  end

endmodule // iilc_issue_ctrl

//--- iilc_issue_ctrl_checker.sv
// Purpose: Timing assertions on the issue interlock ports.
// Assumes: One core clock, synchronous active-high reset.
// Notes:   The class of an issue is the one sampled on its take edge.
`timescale 1ns/1ps
`include "iilc_defs.vh"
// ****************************************************************
// Checker
// ****************************************************************
module iilc_issue_ctrl_checker (
  input wire                   ref_clk_i,
  input wire                   rst_i,
  input wire                   dec_valid_i,
  input wire [`IILC_CLS_W-1:0] dec_class_i,
  input wire [3:0]             dec_rd_i,
  input wire [1:0]             mul_cycles_i,
  input wire                   issue_o,
  input wire                   stall_o,
  input wire                   mem_issue_o,
  input wire                   dual_word_o,
  input wire [3:0]             pair_reg_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Issue and stall only answer a held request
  a_issue_has_req: assert property (issue_o |-> $past(dec_valid_i))
    else $error("issue without request");
  a_stall_has_req: assert property (stall_o |-> $past(dec_valid_i))
    else $error("stall without request");
  a_issue_not_stall: assert property (!(issue_o && stall_o))
    else $error("issue and stall together");
  // Memory flags travel with the issue pulse
  a_mem_with_issue: assert property (mem_issue_o |-> issue_o)
    else $error("memory flag without issue");
  a_dual_even_pair: assert property (dual_word_o |-> mem_issue_o && !pair_reg_o[0])
    else $error("double word pair not even");
  // Occupancy after multi-cycle issues
  a_ldrd_mem_gap: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_LDRD
    |=> !mem_issue_o)
    else $error("memory op right after double load");
  a_ldm_next_stall: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_LDM
    |=> !issue_o [*2])
    else $error("issue too soon after multiple load");
  a_strd_two: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_STRD |=> !issue_o)
    else $error("double store shorter than two");
  a_sreg_two: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_DP_SREG |=> !issue_o)
    else $error("register shift shorter than two");
  a_ldrd_r12_extra: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_LDRD
    && $past(dec_rd_i) == `IILC_R12 |=> !issue_o)
    else $error("double load to r12 without extra cycle");
  a_muls_block: assert property (issue_o && $past(dec_class_i) == `IILC_CLS_MULS
    && $past(mul_cycles_i) == 2'h3 |=> !issue_o [*3])
    else $error("flag multiply did not block");
endmodule // iilc_issue_ctrl_checker

//--- iilc_mem_side.sv
// Purpose: Cache and write buffer side: miss, fill and drain pulses.
// Assumes: Requests come from the bench one cycle ahead.
// Notes:   Never frees a fill buffer that was not taken.
`timescale 1ns/1ps
// ****************************************************************
// Partner model
// ****************************************************************
module iilc_mem_side (
  input  wire ref_clk_i,
  input  wire rst_i,
  input  wire miss_req_i,
  input  wire free_req_i,
  input  wire drain_req_i,
  output reg  dc_miss_o,
  output reg  fill_done_o,
  output reg  wbuf_drain_o
);
  reg  [2:0] fills_q;
  wire       take_w = miss_req_i && (fills_q < 3'h4);
  wire       free_w = free_req_i && (fills_q != 3'h0);
  // At most four fills in flight, one pulse per event
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      fills_q      <= 3'h0;
      dc_miss_o    <= 1'b0;
      fill_done_o  <= 1'b0;
      wbuf_drain_o <= 1'b0;
    end else begin
      fills_q      <= fills_q + {2'h0, take_w} - {2'h0, free_w};
      dc_miss_o    <= take_w;
      fill_done_o  <= free_w;
      wbuf_drain_o <= drain_req_i;
    end
  end
endmodule // iilc_mem_side

//--- iilc_issue_ctrl_bench.sv
// Purpose: Self-checking bench for the issue interlock.
// Assumes: Row = class, rd, source, multiply extra, extend flag, expected stall.
// Notes:   Decode holds each request for exactly its expected wait.
`timescale 1ns/1ps
`include "iilc_defs.vh"
`define CHK(nm, ex, got) begin checked = checked + 1; if ((got) !== (ex)) begin \
  n_mismatch = n_mismatch + 1; $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module iilc_issue_ctrl_bench;
  reg          ref_clk_i, rst_i, dec_valid_i, miss_req, free_req, drain_req;
  reg  [3:0]   dec_class_i, dec_rd_i, dec_src;
  reg          dec_rn_use_i, dec_rm_use_i, dec_rs_use_i, dec_shift_imm_i, dec_rre;
  reg  [15:0]  dec_reg_list_i;
  reg  [1:0]   mul_cycles_i;
  wire         dc_miss, fill_done, wbuf_drain, issue_o, stall_o, mem_issue_o, dual_word_o;
  wire [3:0]   pair_reg_o;
  reg          e_iss, e_stl, e_mem, e_dual;
  reg  [3:0]   e_pair;
  integer      n_mismatch = 0, checked = 0, cyc = 0, i, k;
  logic [19:0] rows [0:32];
  // ****************************************************************
  // Design and partner
  // ****************************************************************
  iilc_issue_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dec_valid_i(dec_valid_i),
    .dec_class_i(dec_class_i), .dec_rd_i(dec_rd_i), .dec_rn_i(dec_src),
    .dec_rn_use_i(dec_rn_use_i), .dec_rm_i(dec_src), .dec_rm_use_i(dec_rm_use_i),
    .dec_rs_i(dec_src), .dec_rs_use_i(dec_rs_use_i), .dec_shift_imm_i(dec_shift_imm_i),
    .dec_rotate_right_extend_i(dec_rre), .dec_reg_list_i(dec_reg_list_i),
    .mul_cycles_i(mul_cycles_i), .dc_miss_i(dc_miss), .fill_done_i(fill_done),
    .wbuf_drain_i(wbuf_drain), .issue_o(issue_o), .stall_o(stall_o),
    .mem_issue_o(mem_issue_o), .dual_word_o(dual_word_o), .pair_reg_o(pair_reg_o));
  iilc_mem_side u_side (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .miss_req_i(miss_req),
    .free_req_i(free_req), .drain_req_i(drain_req), .dc_miss_o(dc_miss),
    .fill_done_o(fill_done), .wbuf_drain_o(wbuf_drain));
  // ****************************************************************
  // Clock, timeout and tasks
  // ****************************************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Cuts a hang short
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 1000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // One edge: compare what the previous edge should have produced
  task tick;
    begin
      @(posedge ref_clk_i);
      `CHK("issue", e_iss, issue_o)
      `CHK("stall", e_stl, stall_o)
      if (e_iss === 1'b1) `CHK("mem", e_mem, mem_issue_o)
      if (e_iss === 1'b1) `CHK("dual", e_dual, dual_word_o)
      if (e_iss && e_dual) `CHK("pair", e_pair, pair_reg_o)
      e_iss = 1'b0;
      e_stl = 1'b0;
    end
  endtask
  task drive(input [19:0] r);
    begin
      dec_valid_i     <= 1'b1;
      dec_class_i     <= r[19:16];
      dec_rd_i        <= r[15:12];
      dec_src         <= r[11:8];
      dec_rre         <= r[3];
      dec_rn_use_i    <= r[19:16] == `IILC_CLS_DP || r[19:16] > `IILC_CLS_DP_SREG;
      dec_rm_use_i    <= r[19:16] == `IILC_CLS_DP_SIMM;
      dec_shift_imm_i <= r[19:16] == `IILC_CLS_DP_SIMM;
      dec_rs_use_i    <= r[19:16] == `IILC_CLS_DP_SREG;
      dec_reg_list_i  <= r[19:16] == `IILC_CLS_LDM ? 16'h000c :
                         r[19:16] == `IILC_CLS_STM ? 16'h0070 : 16'h0000;
      mul_cycles_i    <= r[5:4];
    end
  endtask
  task send(input [19:0] r);
    begin
      drive(r);
      for (k = 0; k <= r[2:0]; k = k + 1) begin
        tick;
        e_stl = k < r[2:0];
        e_iss = k == r[2:0];
        e_mem = r[19:16] >= `IILC_CLS_LDR && r[19:16] <= `IILC_CLS_STM;
        e_dual = r[19:16] == `IILC_CLS_LDRD || r[19:16] == `IILC_CLS_STRD;
        e_pair = r[15:12];
      end
    end
  endtask
  // Held off until the partner frees a resource: freed at the fourth stalled
  // edge, seen by the count two edges on, taken at the seventh edge
  task blocked(input [19:0] r, input integer use_fill);
    begin
      drive(r);
      for (k = 0; k <= 6; k = k + 1) begin
        tick;
        if (k == 3 && use_fill != 0) free_req <= 1'b1;
        if (k == 3 && use_fill == 0) drain_req <= 1'b1;
        if (k == 4) {free_req, drain_req} <= 2'b00;
        e_stl  = k < 6;
        e_iss  = k == 6;
        e_mem  = 1'b1;
        e_dual = 1'b0;
      end
      dec_valid_i <= 1'b0;
      tick;
      `CHK("late issue", 1'b1, issue_o)
    end
  endtask
  task do_reset(input integer n);
    begin
      rst_i       <= 1'b1;
      dec_valid_i <= 1'b0;
      // Outputs are unknown before the first reset edge
      @(posedge ref_clk_i);
      repeat (n - 1) tick;
      rst_i <= 1'b0;
      tick;
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_i, dec_valid_i, miss_req, free_req, drain_req, dec_class_i, dec_rd_i} = 0;
    {dec_src, dec_rn_use_i, dec_rm_use_i, dec_rs_use_i, dec_shift_imm_i, dec_rre} = 0;
    {dec_reg_list_i, mul_cycles_i, e_iss, e_stl, e_mem, e_dual, e_pair} = 0;
    rows = '{20'h01200, 20'h03100, 20'h14301, 20'h25700, 20'h08901, 20'h50300,
             20'h08900, 20'h09102, 20'h44200, 20'h52500, 20'h46801, 20'h5c000,
             20'h08901, 20'h09d01, 20'h64600, 20'h09901, 20'h7f000, 20'h08903,
             20'h8f100, 20'h08904, 20'h37000, 20'h09702, 20'h9a120, 20'h0ba22,
             20'haa130, 20'h08933, 20'h9b100, 20'h9c100, 20'h9d130, 20'h9e103,
             20'h0be01, 20'h01008, 20'h02101};
    do_reset(8);
    for (i = 0; i < 33; i = i + 1) send(rows[i]);
    dec_valid_i <= 1'b0;
    repeat (2) tick;
    do_reset(2);
    repeat (8) send(20'h41000);
    blocked(20'h41000, 0);
    do_reset(2);
    miss_req <= 1'b1;
    repeat (4) tick;
    miss_req <= 1'b0;
    repeat (2) tick;
    blocked(20'h37700, 1);
    wrap_up;
  end
endmodule // iilc_issue_ctrl_bench
bind iilc_issue_ctrl iilc_issue_ctrl_checker u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .dec_valid_i(dec_valid_i), .dec_class_i(dec_class_i), .dec_rd_i(dec_rd_i),
  .mul_cycles_i(mul_cycles_i), .issue_o(issue_o), .stall_o(stall_o),
  .mem_issue_o(mem_issue_o), .dual_word_o(dual_word_o), .pair_reg_o(pair_reg_o));
